/* File: design/strap_mode_decoder.sv */
// strap_mode_decoder: latches strap pins during reset, decodes operating modes
// assumes strap inputs synchronous to aclk; registers over axi4-lite
//
// Implementation choices: the AXI4-Lite interface to the registers and the address map.
module strap_mode_decoder (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [1:0]  debug_mode_select,
  input  wire logic [1:0]  boot_mode_select,
  input  wire logic        byte_order_select,
  input  wire logic        test_port_reset,
  input  wire logic [3:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [3:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  output logic             boundary_scan_mode,
  output logic             emulation_mode,
  output logic             functional_enable,
  output logic             emulation_boot,
  output logic             rom_boot,
  output logic             rom_width_16,
  output logic             little_endian,
  output logic             strap_error
);
  import strap_pkg::*;

  // ****************************************
  // strap capture
  // ****************************************
  // straps follow the pins while reset is low and freeze on release
  logic [1:0] dbg_q;
  logic [1:0] boot_q;
  logic       order_q;
  logic       func_off_q;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      dbg_q <= debug_mode_select;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      boot_q <= boot_mode_select;
    end
  end

  // a reserved order code is still captured so that it can be flagged
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      order_q <= byte_order_select;
    end
  end

  // ****************************************
  // decode
  // ****************************************
  dbg_mode_t dbg_mode;
  assign dbg_mode = (dbg_q == DBG_SCAN) ? DBG_MODE_SCAN :
                    (dbg_q == DBG_EMUL) ? DBG_MODE_EMUL : DBG_MODE_BAD;

  wire scan_d  = (dbg_mode == DBG_MODE_SCAN);
  wire emul_d  = (dbg_mode == DBG_MODE_EMUL);
  // functional run under either debug selection unless software parks it
  wire func_d  = (scan_d | emul_d) & ~func_off_q;
  wire bemu_d  = (boot_q == BOOT_EMUL);
  wire rom_d   = (boot_q == BOOT_ROM8) | (boot_q == BOOT_ROM16);
  wire w16_d   = (boot_q == BOOT_ROM16);
  wire le_d    = order_q;
  // reserved codes are flagged, never given a mode of their own
  wire dbg_rsvd   = (dbg_mode == DBG_MODE_BAD);
  wire boot_rsvd  = ~bemu_d & ~rom_d;
  wire order_rsvd = ~order_q;
  wire bad_d   = dbg_rsvd | boot_rsvd | order_rsvd;

  wire [7:0] mode_word;
  assign mode_word = {bad_d, le_d, w16_d, rom_d, bemu_d, func_d, emul_d, scan_d};

  // ****************************************
  // mode outputs
  // ****************************************
  // one flop per pin, cleared in reset so no stale mode shows early
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      boundary_scan_mode <= 1'b0;
    end else begin
      boundary_scan_mode <= mode_word[F_SCAN];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      emulation_mode <= 1'b0;
    end else begin
      emulation_mode <= mode_word[F_EMUL];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      functional_enable <= 1'b0;
    end else begin
      functional_enable <= mode_word[F_FUNC];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      emulation_boot <= 1'b0;
    end else begin
      emulation_boot <= mode_word[F_BEMU];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rom_boot <= 1'b0;
    end else begin
      rom_boot <= mode_word[F_ROM];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rom_width_16 <= 1'b0;
    end else begin
      rom_width_16 <= mode_word[F_W16];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      little_endian <= 1'b0;
    end else begin
      little_endian <= mode_word[F_LE];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      strap_error <= 1'b0;
    end else begin
      strap_error <= mode_word[F_BAD];
    end
  end

  // ****************************************
  // axi4-lite write channel
  // ****************************************
  logic       aw_held_q;
  logic       w_held_q;
  logic [3:0] aw_addr_q;
  logic       w_bit_q;
  logic       w_en_q;

  wire aw_fire = s_axi_awvalid & s_axi_awready;
  wire w_fire  = s_axi_wvalid & s_axi_wready;
  wire aw_have = aw_held_q | aw_fire;
  wire w_have  = w_held_q | w_fire;
  wire [3:0] wr_addr = aw_held_q ? aw_addr_q : s_axi_awaddr;
  wire       wr_bit  = w_held_q ? w_bit_q : s_axi_wdata[0];
  wire       wr_en   = w_held_q ? w_en_q : s_axi_wstrb[0];
  wire       wr_go   = aw_have & w_have & ~s_axi_bvalid;
  wire       wr_ctrl = (wr_addr == ADDR_CTRL);
  wire       wr_ok   = wr_ctrl | (wr_addr == ADDR_MODE) | (wr_addr == ADDR_STRAPS);

  // a taken side drops its ready until the response has gone
  wire       awready_d  = ~aw_have & ~s_axi_awready & ~s_axi_bvalid;
  wire       wready_d   = ~w_have & ~s_axi_wready & ~s_axi_bvalid;
  wire       aw_held_d  = aw_have & ~wr_go;
  wire       w_held_d   = w_have & ~wr_go;
  wire [3:0] aw_addr_d  = aw_fire ? s_axi_awaddr : aw_addr_q;
  wire       w_bit_d    = w_fire ? s_axi_wdata[0] : w_bit_q;
  wire       w_en_d     = w_fire ? s_axi_wstrb[0] : w_en_q;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
    end else begin
      s_axi_awready <= awready_d;
      s_axi_wready  <= wready_d;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_q <= 1'b0;
      w_held_q  <= 1'b0;
    end else begin
      aw_held_q <= aw_held_d;
      w_held_q  <= w_held_d;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_addr_q <= 4'h0;
      w_bit_q   <= 1'b0;
      w_en_q    <= 1'b0;
    end else begin
      aw_addr_q <= aw_addr_d;
      w_bit_q   <= w_bit_d;
      w_en_q    <= w_en_d;
    end
  end

  // ****************************************
  // write response
  // ****************************************
  // the response stands until the master takes it
  wire       bvalid_d   = wr_go | (s_axi_bvalid & ~s_axi_bready);
  wire [1:0] wr_resp    = wr_ok ? RESP_OKAY : RESP_SLVERR;
  wire [1:0] bresp_d    = wr_go ? wr_resp : s_axi_bresp;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
    end else begin
      s_axi_bvalid <= bvalid_d;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bresp <= RESP_OKAY;
    end else begin
      s_axi_bresp <= bresp_d;
    end
  end

  // ****************************************
  // control register
  // ****************************************
  // only bit 0 is kept; the park holds until cleared or reset
  wire       ctrl_hit   = wr_go & wr_ctrl & wr_en;
  wire       func_off_d = ctrl_hit ? wr_bit : func_off_q;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      func_off_q <= 1'b0;
    end else begin
      func_off_q <= func_off_d;
    end
  end

  // ****************************************
  // axi4-lite read channel
  // ****************************************
  // address decoded straight off the bus; data latched on the handshake
  wire        rd_mode   = (s_axi_araddr == ADDR_MODE);
  wire        rd_straps = (s_axi_araddr == ADDR_STRAPS);
  wire        rd_ctrl   = (s_axi_araddr == ADDR_CTRL);
  wire        rd_ok     = rd_mode | rd_straps | rd_ctrl;
  wire [31:0] mode_rd   = {24'h00_0000, mode_word};
  wire [31:0] straps_rd = {27'h000_0000, order_q, boot_q, dbg_q};
  wire [31:0] ctrl_rd   = {31'h0000_0000, func_off_q};
  // unmapped offsets read as zero with an error response
  wire [31:0] rd_mux    = rd_mode   ? mode_rd   :
                          rd_straps ? straps_rd :
                          rd_ctrl   ? ctrl_rd   : 32'h0000_0000;
  wire        ar_fire   = s_axi_arvalid & s_axi_arready;
  // no ready while read data waits, so one read at most is open
  wire        arready_d = s_axi_arvalid & ~s_axi_arready & ~s_axi_rvalid;
  wire        rvalid_d  = ar_fire | (s_axi_rvalid & ~s_axi_rready);
  wire [31:0] rdata_d   = ar_fire ? rd_mux : s_axi_rdata;
  wire [1:0]  rd_resp   = rd_ok ? RESP_OKAY : RESP_SLVERR;
  wire [1:0]  rresp_d   = ar_fire ? rd_resp : s_axi_rresp;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
    end else begin
      s_axi_arready <= arready_d;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
    end else begin
      s_axi_rvalid <= rvalid_d;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= RESP_OKAY;
    end else begin
      s_axi_rdata <= rdata_d;
      s_axi_rresp <= rresp_d;
    end
  end

  // ****************************************
  // test-port reset
  // ****************************************
  // observed only; scan depends on the board leaving it at its pulldown
  wire unused_tpr = test_port_reset;

endmodule : strap_mode_decoder

/* File: design/strap_pkg.sv */
// strap_pkg: constants, register map and decode types for the strap mode decoder
// assumes a 20 MHz aclk and a 32-bit axi4-lite register bus
// Function
// - selector 00 selects boundary-scan configuration, functional operation still possible
// - selector 11 selects emulation with functional operation; default when undriven
// - functional mode available under both boundary scan and emulation
// - boot selector 01 boots 8-bit async rom on space one; default
// - boot selector 10 boots 16-bit async rom on space one
// - byte order select 1 means little endian; 0 is reserved
package strap_pkg;

  // ****************************************
  // register map
  // ****************************************
  localparam logic [3:0]  ADDR_MODE   = 4'h0;
  localparam logic [3:0]  ADDR_STRAPS = 4'h4;
  localparam logic [3:0]  ADDR_CTRL   = 4'h8;

  // ****************************************
  // strap codes and reset values
  // ****************************************
  localparam logic [1:0]  DBG_SCAN     = 2'h0;
  localparam logic [1:0]  DBG_EMUL     = 2'h3;
  localparam logic [1:0]  DBG_RESET    = 2'h3;
  localparam logic [1:0]  BOOT_EMUL    = 2'h0;
  localparam logic [1:0]  BOOT_ROM8    = 2'h1;
  localparam logic [1:0]  BOOT_ROM16   = 2'h2;
  localparam logic [1:0]  BOOT_RESET   = 2'h1;
  localparam logic        ORDER_RESET  = 1'b1;
  localparam logic [1:0]  RESP_OKAY    = 2'h0;
  localparam logic [1:0]  RESP_SLVERR  = 2'h2;

  // mode register fields
  localparam int          F_SCAN   = 0;
  localparam int          F_EMUL   = 1;
  localparam int          F_FUNC   = 2;
  localparam int          F_BEMU   = 3;
  localparam int          F_ROM    = 4;
  localparam int          F_W16    = 5;
  localparam int          F_LE     = 6;
  localparam int          F_BAD    = 7;

  typedef enum logic [1:0] {
    DBG_MODE_SCAN = 2'h0,
    DBG_MODE_EMUL = 2'h1,
    DBG_MODE_BAD  = 2'h3
  } dbg_mode_t;

endpackage : strap_pkg

/* File: test/strap_board.sv */
// strap_board: board strapping and test-port reset seen by the decoder
// assumes the bench sets request by non-blocking assignment after aclk edges
module strap_board (
  input  wire logic [4:0] request,
  output logic [1:0]      debug_mode_select,
  output logic [1:0]      boot_mode_select,
  output logic            byte_order_select,
  output logic            test_port_reset
);
  // reserved codes only when a scenario asks for them
  assign {byte_order_select, boot_mode_select, debug_mode_select} = request;
  assign test_port_reset = 1'b0; // pulldown left unopposed
endmodule : strap_board

/* File: test/strap_props.sv */
// strap_props: port checks of the strap mode decoder
// assumes a bind onto strap_mode_decoder, single clock aclk
module strap_props
  import strap_pkg::*;
(
  input wire logic       aclk,
  input wire logic       aresetn,
  input wire logic [1:0] debug_mode_select,
  input wire logic [1:0] boot_mode_select,
  input wire logic       byte_order_select,
  input wire logic       boundary_scan_mode,
  input wire logic       emulation_mode,
  input wire logic       functional_enable,
  input wire logic       emulation_boot,
  input wire logic       rom_boot,
  input wire logic       rom_width_16,
  input wire logic       little_endian,
  input wire logic       strap_error
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  chk_scan_decode: assert property ($rose(aresetn) |=>
    boundary_scan_mode == ($past(debug_mode_select, 2) == DBG_SCAN)) else $error("scan decode");
  chk_emul_decode: assert property ($rose(aresetn) |=>
    emulation_mode == ($past(debug_mode_select, 2) == DBG_EMUL)) else $error("emul decode");
  chk_func_enable: assert property ($rose(aresetn) |=>
    functional_enable == (boundary_scan_mode || emulation_mode)) else $error("func enable");
  chk_emu_boot: assert property ($rose(aresetn) |=>
    emulation_boot == ($past(boot_mode_select, 2) == BOOT_EMUL)) else $error("emu boot");
  chk_rom_boot: assert property ($rose(aresetn) |=>
    rom_boot == (^$past(boot_mode_select, 2))) else $error("rom boot");
  chk_rom_width: assert property ($rose(aresetn) |=>
    rom_width_16 == ($past(boot_mode_select, 2) == BOOT_ROM16)) else $error("rom width");
  chk_order_error: assert property ($rose(aresetn) |=> little_endian == $past(byte_order_select, 2)
    && strap_error == (^$past(debug_mode_select, 2) || &$past(boot_mode_select, 2)
    || !$past(byte_order_select, 2))) else $error("order or error flag");
  chk_modes_hold: assert property (aresetn && $past(aresetn) && $past(aresetn, 2) |->
    $stable({boundary_scan_mode, emulation_mode, emulation_boot, rom_boot, rom_width_16,
    little_endian, strap_error})) else $error("modes moved after capture");
endmodule : strap_props

bind strap_mode_decoder strap_props u_props (
  .aclk(aclk), .aresetn(aresetn), .debug_mode_select(debug_mode_select),
  .boot_mode_select(boot_mode_select), .byte_order_select(byte_order_select),
  .boundary_scan_mode(boundary_scan_mode), .emulation_mode(emulation_mode),
  .functional_enable(functional_enable), .emulation_boot(emulation_boot),
  .rom_boot(rom_boot), .rom_width_16(rom_width_16), .little_endian(little_endian),
  .strap_error(strap_error)
);

/* File: test/tb.sv */
// tb: strap decode checks through the mode pins and the axi4-lite registers
// assumes strap_pkg constants; straps come from strap_board
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  import strap_pkg::*;
  logic        aclk = 1'b0;
  logic        aresetn = 1'b0;
  logic [4:0]  request = 5'h17;
  logic [3:0]  awaddr = 4'h0, araddr = 4'h0;
  logic [31:0] wdata = 32'h0000_0000, d;
  logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [1:0]  r;
  wire  [1:0]  dbg, boot, bresp, rresp;
  wire         order, tpr, awready, wready, bvalid, arready, rvalid;
  wire  [31:0] rdata;
  wire  [7:0]  pins;
  int          bad_count = 0, tests_run = 0;
  // reserved strap codes last: they must raise the error flag
  logic [4:0]  cases [5] = '{5'h10, 5'h17, 5'h1b, 5'h0d, 5'h06};

  strap_board board (.request(request), .debug_mode_select(dbg), .boot_mode_select(boot),
    .byte_order_select(order), .test_port_reset(tpr));
  strap_mode_decoder dut (.aclk(aclk), .aresetn(aresetn), .debug_mode_select(dbg),
    .boot_mode_select(boot), .byte_order_select(order), .test_port_reset(tpr),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .boundary_scan_mode(pins[0]), .emulation_mode(pins[1]), .functional_enable(pins[2]),
    .emulation_boot(pins[3]), .rom_boot(pins[4]), .rom_width_16(pins[5]),
    .little_endian(pins[6]), .strap_error(pins[7]));

  initial forever #25 aclk = ~aclk;

  // ****************************************
  // bus cycles and checks
  // ****************************************
  task automatic wr(input logic [3:0] a, input logic [31:0] v, output logic [1:0] resp);
    @(posedge aclk);
    awaddr <= a; wdata <= v; awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid);
    resp = bresp;
    bready <= 1'b0;
  endtask : wr

  task automatic rd(input logic [3:0] a, output logic [31:0] v, output logic [1:0] resp);
    @(posedge aclk);
    araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
    end while (!rvalid);
    v = rdata;
    resp = rresp;
    rready <= 1'b0;
  endtask : rd

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk

  function automatic logic [7:0] mode_of(input logic [4:0] s);
    return {^s[1:0] || &s[3:2] || !s[4], s[4], s[3:2] == BOOT_ROM16, ^s[3:2],
      s[3:2] == BOOT_EMUL, s[1:0] == DBG_SCAN || s[1:0] == DBG_EMUL, s[1:0] == DBG_EMUL,
      s[1:0] == DBG_SCAN};
  endfunction : mode_of

  task automatic restart(input logic [4:0] s);
    @(posedge aclk);
    aresetn <= 1'b0;
    request <= s; // case straps set while reset is low
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
  endtask : restart

  task automatic results();
    $display("checks %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : results

  initial begin
    repeat (4000) @(posedge aclk);
    bad_count++;
    results();
  end

  initial begin
    foreach (cases[i]) begin
      restart(cases[i]);
      chk({24'h0, pins}, {24'h0, mode_of(cases[i])});
      rd(ADDR_MODE, d, r);
      chk(d, {24'h0, mode_of(cases[i])});
      rd(ADDR_STRAPS, d, r);
      chk(d, {27'h0, cases[i]});
    end
    request <= 5'h10;
    wr(ADDR_MODE, 32'h0000_0000, r);
    chk({30'h0, r}, {30'h0, RESP_OKAY});
    rd(ADDR_MODE, d, r);
    chk(d, {24'h0, mode_of(5'h06)});
    chk({24'h0, pins}, {24'h0, mode_of(5'h06)});
    restart(5'h17);
    wr(ADDR_CTRL, 32'h0000_0001, r);
    chk({30'h0, r}, {30'h0, RESP_OKAY});
    rd(ADDR_MODE, d, r);
    chk(d, {24'h0, mode_of(5'h17) & 8'hfb});
    chk({24'h0, pins}, {24'h0, mode_of(5'h17) & 8'hfb});
    rd(ADDR_CTRL, d, r);
    chk(d, 32'h0000_0001);
    chk({30'h0, r}, {30'h0, RESP_OKAY});
    wr(ADDR_CTRL, 32'h0000_0000, r);
    rd(ADDR_MODE, d, r);
    chk(d, {24'h0, mode_of(5'h17)});
    chk({24'h0, pins}, {24'h0, mode_of(5'h17)});
    rd(4'hc, d, r);
    chk({r, d[29:0]}, {RESP_SLVERR, 30'h0});
    wr(4'hc, 32'h0000_0001, r);
    chk({30'h0, r}, {30'h0, RESP_SLVERR});
    results();
  end
endmodule : tb
